// [design/port_and_lcd_pin_function_mux.sv]
/*
 * Pin function multiplexer for pins 22 to 27 and LCD-capable pins of ports 3, 4, 5,
 * with its select registers on an APB slave.
 * Assumes the UART, timers, energy pulse, PLL and LCD blocks run on pclk and that
 * every pad input is asynchronous to pclk.
 */
// Design decision made here: the APB interface to the registers.
// Functional notes
// - pin 23 select picks GPIO, UART1 transmit, timer2 trigger or interrupt 3
// - interrupt 3 fires on a falling edge of pin 23
// - pin 24 select picks GPIO, UART1 receive, timer1 input or falling-edge interrupt 2
// - select register bit chooses fast GPIO or path 1 energy pulse on pin 25
// - select register bit chooses fast GPIO or path 2 energy pulse on pin 26
// - pin 27 outputs divided PLL pulses or one-second PLL counter pulses
// - pin 22 wakes from sleep on a software-chosen transition
// - port 3 pins 0-3 reset to GPIO, switchable to LCD backplanes 0-3
// - port 4 pins 0-1 are GPIO by default, LCD segments 0-1 at type 0
// - port 4 pins 0-1 become LCD backplanes 4-5 at type 1, 2 or 3
// - port 5 pins 0-1 are GPIO by default, LCD segments 8-9 at type 0 or 1
// - port 5 pins 0-1 become LCD backplanes 6-7 at type 2 or 3
module port_and_lcd_pin_function_mux
    import pin_mux_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_PADS-1:0] pad_in,
    output logic [NUM_PADS-1:0] pad_out,
    output logic [NUM_PADS-1:0] pad_oe,
    input wire logic [NUM_PADS-1:0] gpio_out,
    input wire logic [NUM_PADS-1:0] gpio_oe,
    output logic [NUM_PADS-1:0] gpio_in,
    input wire logic uart1_transmit_out,
    output logic uart1_receive_in,
    output logic timer2_capture_reload_trigger,
    output logic timer1_external_input,
    output logic io_interrupt_input_2,
    output logic io_interrupt_input_3,
    input wire logic energy_pulse_path1,
    input wire logic energy_pulse_path2,
    input wire logic divided_pll_pulse_out,
    input wire logic pll_second_pulse,
    output logic wake_input_2,
    input wire logic [7:0] lcd_backplane_in,
    input wire logic [1:0] lcd_segment_lo_in,
    input wire logic [1:0] lcd_segment_hi_in
);

    typedef struct packed {
        logic [7:0] fast_io_cf_pin_select;
        logic [7:0] pin24_function_select;
        logic [7:0] pin23_function_select;
        logic [7:0] lcd_control;
        logic [7:0] lcd_pin_enable;
        logic [7:0] wake_config;
        logic [7:0] pll_pulse_config;
        logic [NUM_PADS-1:0] sync1;
        logic [NUM_PADS-1:0] sync2;
        logic [NUM_PADS-1:0] prev;
        logic [NUM_PADS-1:0] pout;
        logic [NUM_PADS-1:0] poe;
        logic wake_pending;
        logic io_interrupt_input_2_pulse;
        logic io_interrupt_input_3_pulse;
        logic [31:0] rdata;
    } state_t;

    state_t q;
    state_t d;

    function automatic logic reg_mapped(input logic [13:0] idx);
        case (idx)
            IDX_FAST_IO_CF, IDX_PIN24_FSEL, IDX_PIN23_FSEL, IDX_LCD_CTRL,
            IDX_LCD_PIN_EN, IDX_WAKE_CFG, IDX_PLL_CFG, IDX_PIN_STATUS: reg_mapped = 1'b1;
            default: reg_mapped = 1'b0;
        endcase
    endfunction

    logic [13:0] idx;
    logic aligned;
    logic hit;
    logic setup_ph;
    logic access_ph;
    logic wr;
    logic [7:0] rd_val;
    logic [LCD_TYPE_W-1:0] lcd_type_field;
    logic [NUM_PADS-1:0] fn_sel;
    logic [NUM_PADS-1:0] fn_out;
    logic [NUM_PADS-1:0] fn_oe;
    logic [NUM_PADS-1:0] fall;
    logic [NUM_PADS-1:0] rise;
    logic wake_edge;
    logic [1:0] wake_mode;

    assign idx = paddr[15:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign hit = aligned && reg_mapped(idx);
    assign setup_ph = psel && !penable;
    assign access_ph = psel && penable;
    assign wr = access_ph && pwrite && hit && pstrb[0];
    assign lcd_type_field = q.lcd_control[LCD_TYPE_LSB +: LCD_TYPE_W];
    assign fall = q.prev & ~q.sync2;
    assign rise = ~q.prev & q.sync2;
    assign wake_mode = q.wake_config[WK_EDGE_LSB +: 2];

    // read value chosen during the setup phase
    always_comb begin
        case (idx)
            IDX_FAST_IO_CF: rd_val = q.fast_io_cf_pin_select;
            IDX_PIN24_FSEL: rd_val = q.pin24_function_select;
            IDX_PIN23_FSEL: rd_val = q.pin23_function_select;
            IDX_LCD_CTRL: rd_val = q.lcd_control;
            IDX_LCD_PIN_EN: rd_val = q.lcd_pin_enable;
            IDX_WAKE_CFG: rd_val = q.wake_config;
            IDX_PLL_CFG: rd_val = q.pll_pulse_config;
            IDX_PIN_STATUS: rd_val = {q.wake_pending, 4'h0, q.sync2[PAD_PIN24],
                q.sync2[PAD_PIN23], q.sync2[PAD_PIN22]};
            default: rd_val = 8'h00;
        endcase
    end

    // wake edge selection
    always_comb begin
        case (wake_mode)
            WK_EDGE_RISE: wake_edge = rise[PAD_PIN22];
            WK_EDGE_FALL: wake_edge = fall[PAD_PIN22];
            default: wake_edge = rise[PAD_PIN22] | fall[PAD_PIN22];
        endcase
    end

    // per-pad function selection
    always_comb begin
        fn_sel = '0;
        fn_out = '0;
        fn_oe = '0;
        case (q.pin23_function_select)
            P23_UART1_TX: begin
                fn_sel[PAD_PIN23] = 1'b1;
                fn_out[PAD_PIN23] = uart1_transmit_out;
                fn_oe[PAD_PIN23] = 1'b1;
            end
            P23_T2_TRIG, P23_IO_INTERRUPT_INPUT_3: begin
                fn_sel[PAD_PIN23] = 1'b1;
            end
            default: begin
                fn_sel[PAD_PIN23] = 1'b0;
            end
        endcase
        case (q.pin24_function_select)
            P24_UART1_RX, P24_T1_IN, P24_IO_INTERRUPT_INPUT_2: begin
                fn_sel[PAD_PIN24] = 1'b1;
            end
            default: begin
                fn_sel[PAD_PIN24] = 1'b0;
            end
        endcase
        if (q.fast_io_cf_pin_select[FS_CF1_BIT]) begin
            fn_sel[PAD_PIN25] = 1'b1;
            fn_out[PAD_PIN25] = energy_pulse_path1;
            fn_oe[PAD_PIN25] = 1'b1;
        end
        if (q.fast_io_cf_pin_select[FS_CF2_BIT]) begin
            fn_sel[PAD_PIN26] = 1'b1;
            fn_out[PAD_PIN26] = energy_pulse_path2;
            fn_oe[PAD_PIN26] = 1'b1;
        end
        if (q.fast_io_cf_pin_select[FS_PLL_BIT]) begin
            fn_sel[PAD_PIN27] = 1'b1;
            fn_out[PAD_PIN27] = q.pll_pulse_config[PLL_SEC_BIT] ? pll_second_pulse
                : divided_pll_pulse_out;
            fn_oe[PAD_PIN27] = 1'b1;
        end
        for (int i = 0; i < 4; i++) begin
            if (q.lcd_pin_enable[LPE_PORT3_BIT]) begin
                fn_sel[PAD_PORT3 + i] = 1'b1;
                fn_out[PAD_PORT3 + i] = lcd_backplane_in[i];
                fn_oe[PAD_PORT3 + i] = 1'b1;
            end
        end
        for (int i = 0; i < 2; i++) begin
            if (q.lcd_pin_enable[LPE_PORT4_BIT]) begin
                fn_sel[PAD_PORT4 + i] = 1'b1;
                fn_oe[PAD_PORT4 + i] = 1'b1;
                if (lcd_type_field == 2'h0) begin
                    fn_out[PAD_PORT4 + i] = lcd_segment_lo_in[i];
                end else begin
                    fn_out[PAD_PORT4 + i] = lcd_backplane_in[4 + i];
                end
            end
            if (q.lcd_pin_enable[LPE_PORT5_BIT]) begin
                fn_sel[PAD_PORT5 + i] = 1'b1;
                fn_oe[PAD_PORT5 + i] = 1'b1;
                if (lcd_type_field < 2'h2) begin
                    fn_out[PAD_PORT5 + i] = lcd_segment_hi_in[i];
                end else begin
                    fn_out[PAD_PORT5 + i] = lcd_backplane_in[6 + i];
                end
            end
        end
    end

    // next state
    always_comb begin
        d = q;
        d.sync1 = pad_in;
        d.sync2 = q.sync1;
        d.prev = q.sync2;
        for (int i = 0; i < NUM_PADS; i++) begin
            d.pout[i] = fn_sel[i] ? fn_out[i] : gpio_out[i];
            d.poe[i] = fn_sel[i] ? fn_oe[i] : gpio_oe[i];
        end
        d.io_interrupt_input_3_pulse = fall[PAD_PIN23] && (q.pin23_function_select == P23_IO_INTERRUPT_INPUT_3);
        d.io_interrupt_input_2_pulse = fall[PAD_PIN24] && (q.pin24_function_select == P24_IO_INTERRUPT_INPUT_2);
        if (setup_ph) begin
            d.rdata = hit ? {24'h000000, rd_val} : 32'h00000000;
        end
        if (wr) begin
            case (idx)
                IDX_FAST_IO_CF: d.fast_io_cf_pin_select = pwdata[7:0];
                IDX_PIN24_FSEL: d.pin24_function_select = pwdata[7:0];
                IDX_PIN23_FSEL: d.pin23_function_select = pwdata[7:0];
                IDX_LCD_CTRL: d.lcd_control = pwdata[7:0];
                IDX_LCD_PIN_EN: d.lcd_pin_enable = pwdata[7:0];
                IDX_WAKE_CFG: d.wake_config = pwdata[7:0];
                IDX_PLL_CFG: d.pll_pulse_config = pwdata[7:0];
                IDX_PIN_STATUS: begin
                    if (pwdata[ST_WAKE_BIT]) begin
                        d.wake_pending = 1'b0;
                    end
                end
                default: d.rdata = q.rdata;
            endcase
        end
        // set beats a simultaneous clear
        if (q.wake_config[WK_EN_BIT] && wake_edge) begin
            d.wake_pending = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q.fast_io_cf_pin_select <= RST_FAST_IO_CF;
            q.pin24_function_select <= RST_PIN24_FSEL;
            q.pin23_function_select <= RST_PIN23_FSEL;
            q.lcd_control <= RST_LCD_CTRL;
            q.lcd_pin_enable <= RST_LCD_PIN_EN;
            q.wake_config <= RST_WAKE_CFG;
            q.pll_pulse_config <= RST_PLL_CFG;
            q.sync1 <= '0;
            q.sync2 <= '0;
            q.prev <= '0;
            q.pout <= '0;
            q.poe <= '0;
            q.wake_pending <= 1'b0;
            q.io_interrupt_input_2_pulse <= 1'b0;
            q.io_interrupt_input_3_pulse <= 1'b0;
            q.rdata <= 32'h00000000;
        end else begin
            q <= d;
        end
    end

    assign prdata = q.rdata;
    assign pready = 1'b1;
    assign pslverr = access_ph && !hit;
    assign pad_out = q.pout;
    assign pad_oe = q.poe;
    assign gpio_in = q.sync2;
    assign uart1_receive_in = (q.pin24_function_select == P24_UART1_RX) ?
        q.sync2[PAD_PIN24] : 1'b1;
    assign timer1_external_input = (q.pin24_function_select == P24_T1_IN) ?
        q.sync2[PAD_PIN24] : 1'b0;
    assign timer2_capture_reload_trigger = (q.pin23_function_select == P23_T2_TRIG) ?
        q.sync2[PAD_PIN23] : 1'b0;
    assign io_interrupt_input_2 = q.io_interrupt_input_2_pulse;
    assign io_interrupt_input_3 = q.io_interrupt_input_3_pulse;
    assign wake_input_2 = q.wake_pending;

endmodule

// [design/pin_mux_pkg.sv]
/*
 * Constants for the pin function multiplexer: register indices, field positions,
 * select encodings, reset values and pad positions.
 * Assumes an APB slave whose byte address is four times the register index.
 */
package pin_mux_pkg;
    // register indices, byte address = index * 4
    localparam logic [13:0] IDX_FAST_IO_CF = 14'h00AD;
    localparam logic [13:0] IDX_PIN24_FSEL = 14'h28C5;
    localparam logic [13:0] IDX_PIN23_FSEL = 14'h28C6;
    localparam logic [13:0] IDX_LCD_CTRL = 14'h2C1E;
    localparam logic [13:0] IDX_LCD_PIN_EN = 14'h2C20;
    localparam logic [13:0] IDX_WAKE_CFG = 14'h2C21;
    localparam logic [13:0] IDX_PLL_CFG = 14'h2C22;
    localparam logic [13:0] IDX_PIN_STATUS = 14'h2C23;

    // reset values: every pin comes up as general-purpose I/O
    localparam logic [7:0] RST_FAST_IO_CF = 8'h00;
    localparam logic [7:0] RST_PIN24_FSEL = 8'h00;
    localparam logic [7:0] RST_PIN23_FSEL = 8'h00;
    localparam logic [7:0] RST_LCD_CTRL = 8'h00;
    localparam logic [7:0] RST_LCD_PIN_EN = 8'h00;
    localparam logic [7:0] RST_WAKE_CFG = 8'h00;
    localparam logic [7:0] RST_PLL_CFG = 8'h00;

    // pin 23 select encodings
    localparam logic [7:0] P23_GPIO = 8'h00;
    localparam logic [7:0] P23_UART1_TX = 8'h01;
    localparam logic [7:0] P23_T2_TRIG = 8'h02;
    localparam logic [7:0] P23_IO_INTERRUPT_INPUT_3 = 8'h03;
    // pin 24 select encodings
    localparam logic [7:0] P24_GPIO = 8'h00;
    localparam logic [7:0] P24_UART1_RX = 8'h01;
    localparam logic [7:0] P24_T1_IN = 8'h02;
    localparam logic [7:0] P24_IO_INTERRUPT_INPUT_2 = 8'h03;

    // fast_io_cf_pin_select bit positions
    localparam int FS_CF1_BIT = 6;
    localparam int FS_CF2_BIT = 5;
    localparam int FS_PLL_BIT = 3;
    // lcd_control field
    localparam int LCD_TYPE_LSB = 4;
    localparam int LCD_TYPE_W = 2;
    // lcd_pin_enable bit positions
    localparam int LPE_PORT3_BIT = 0;
    localparam int LPE_PORT4_BIT = 1;
    localparam int LPE_PORT5_BIT = 2;
    // wake_config fields
    localparam int WK_EN_BIT = 0;
    localparam int WK_EDGE_LSB = 1;
    localparam logic [1:0] WK_EDGE_ANY = 2'h0;
    localparam logic [1:0] WK_EDGE_RISE = 2'h1;
    localparam logic [1:0] WK_EDGE_FALL = 2'h2;
    // pll_pulse_config: 1 selects one-second pulses
    localparam int PLL_SEC_BIT = 0;
    // pin_status: wake pending flag
    localparam int ST_WAKE_BIT = 7;

    // pad positions in the pad vectors
    localparam int NUM_PADS = 14;
    localparam int PAD_PIN22 = 0;
    localparam int PAD_PIN23 = 1;
    localparam int PAD_PIN24 = 2;
    localparam int PAD_PIN25 = 3;
    localparam int PAD_PIN26 = 4;
    localparam int PAD_PIN27 = 5;
    localparam int PAD_PORT3 = 6;
    localparam int PAD_PORT4 = 10;
    localparam int PAD_PORT5 = 12;
endpackage

// [test/pin_mux_checker.sv]
/*
 * Port-level assertions for the pin function multiplexer.
 * Assumes it is bound into the top module and sees only its ports.
 */
module pin_mux_checker
    import pin_mux_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [NUM_PADS-1:0] gpio_in,
    input wire logic [NUM_PADS-1:0] pad_oe,
    input wire logic uart1_receive_in,
    input wire logic timer2_capture_reload_trigger,
    input wire logic timer1_external_input,
    input wire logic io_interrupt_input_2,
    input wire logic io_interrupt_input_3,
    input wire logic wake_input_2
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    io_interrupt_input_3_fall_src_a: assert property (io_interrupt_input_3 |-> !$past(gpio_in[PAD_PIN23])
        && ($past(gpio_in[PAD_PIN23], 2) || $past(gpio_in[PAD_PIN23], 3)))
        else $error("irq3 without falling pin");
    io_interrupt_input_2_fall_src_a: assert property (io_interrupt_input_2 |-> !$past(gpio_in[PAD_PIN24])
        && ($past(gpio_in[PAD_PIN24], 2) || $past(gpio_in[PAD_PIN24], 3)))
        else $error("irq2 without falling pin");
    io_interrupt_input_3_one_cycle_a: assert property (io_interrupt_input_3 |=> !io_interrupt_input_3)
        else $error("irq3 longer than one cycle");
    io_interrupt_input_2_one_cycle_a: assert property (io_interrupt_input_2 |=> !io_interrupt_input_2)
        else $error("irq2 longer than one cycle");
    t2_level_src_a: assert property (timer2_capture_reload_trigger |->
        gpio_in[PAD_PIN23] || $past(gpio_in[PAD_PIN23])) else $error("trigger high, pin low");
    t1_level_src_a: assert property (timer1_external_input |->
        gpio_in[PAD_PIN24] || $past(gpio_in[PAD_PIN24])) else $error("timer1 high, pin low");
    rx_level_src_a: assert property (!uart1_receive_in |->
        !gpio_in[PAD_PIN24] || !$past(gpio_in[PAD_PIN24])) else $error("rx low, pin high");
    t2_input_oe_a: assert property (timer2_capture_reload_trigger &&
        $past(timer2_capture_reload_trigger) |-> !pad_oe[PAD_PIN23])
        else $error("pin 23 driven as input");
    pin24_fn_excl_a: assert property (!(timer1_external_input && !uart1_receive_in))
        else $error("two pin 24 functions at once");
    wake_edge_src_a: assert property ($rose(wake_input_2) |->
        $past(gpio_in[PAD_PIN22]) != $past(gpio_in[PAD_PIN22], 2) ||
        $past(gpio_in[PAD_PIN22], 2) != $past(gpio_in[PAD_PIN22], 3))
        else $error("wake without pin change");

    irq3_seen_c: cover property (io_interrupt_input_3);
    irq2_seen_c: cover property (io_interrupt_input_2);
    trig_seen_c: cover property (timer2_capture_reload_trigger);
    wake_seen_c: cover property ($rose(wake_input_2));
endmodule

bind port_and_lcd_pin_function_mux pin_mux_checker u_chk (.pclk, .presetn, .gpio_in, .pad_oe,
    .uart1_receive_in, .timer2_capture_reload_trigger, .timer1_external_input,
    .io_interrupt_input_2, .io_interrupt_input_3, .wake_input_2);

// [test/tb_port_and_lcd_pin_function_mux.sv]
/*
 * Self-checking bench for the pin function multiplexer.
 * Drives the APB side and all pad and peripheral inputs itself; no far-side model.
 */
module tb_port_and_lcd_pin_function_mux
    import pin_mux_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [NUM_PADS-1:0] pad_in, pad_out, pad_oe, gpio_out, gpio_oe, gpio_in;
    logic uart1_transmit_out, uart1_receive_in, timer2_capture_reload_trigger;
    logic timer1_external_input, io_interrupt_input_2, io_interrupt_input_3, wake_input_2;
    logic energy_pulse_path1, energy_pulse_path2, divided_pll_pulse_out, pll_second_pulse;
    logic [7:0] lcd_backplane_in;
    logic [1:0] lcd_segment_lo_in, lcd_segment_hi_in, lt;
    logic [13:0] regs [7] = '{IDX_FAST_IO_CF, IDX_PIN24_FSEL, IDX_PIN23_FSEL, IDX_LCD_CTRL,
        IDX_LCD_PIN_EN, IDX_WAKE_CFG, IDX_PLL_CFG};
    logic [7:0] sels [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h07};
    logic [7:0] wcfg [3] = '{8'h01, 8'h03, 8'h05};
    int fails, samples_checked, i, j;

    port_and_lcd_pin_function_mux dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .pad_in, .pad_out, .pad_oe, .gpio_out,
        .gpio_oe, .gpio_in, .uart1_transmit_out, .uart1_receive_in,
        .timer2_capture_reload_trigger, .timer1_external_input, .io_interrupt_input_2,
        .io_interrupt_input_3, .energy_pulse_path1, .energy_pulse_path2,
        .divided_pll_pulse_out, .pll_second_pulse, .wake_input_2, .lcd_backplane_in,
        .lcd_segment_lo_in, .lcd_segment_hi_in);

    task automatic report_and_stop();
        $display("fails %0d samples_checked %0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    task automatic apb(input logic [13:0] idx, input logic w, input logic [7:0] wd,
            output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            fails++;
            $display("BAD %0t apb transfer never answered", $time);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [13:0] idx, input logic [7:0] wd);
        logic [31:0] rd;
        logic err;
        apb(idx, 1'b1, wd, rd, err);
    endtask

    task automatic rdchk(input logic [13:0] idx, input logic [7:0] exp, input logic xerr);
        logic [31:0] rd;
        logic err;
        apb(idx, 1'b0, 8'h00, rd, err);
        chk(rd, {24'h000000, exp}, "read data");
        chk(err, xerr, "read error");
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    // one select value on pin 23 (p=1) or pin 24 (p=2): drive, level, falling edge
    task automatic pin_fn(input logic [13:0] idx, input int p, input logic [7:0] s);
        int k;
        int pulses;
        logic gp;
        gp = (s == 8'h00 || s > 8'h03);
        wr(idx, s);
        @(posedge pclk);
        pad_in[p] <= 1'b1;
        settle(6);
        chk(pad_oe[p], gp ? gpio_oe[p] : (p == 1 && s == 8'h01), "pin oe");
        if (gp || (p == 1 && s == 8'h01)) begin
            chk(pad_out[p], gp ? gpio_out[p] : uart1_transmit_out, "pin out");
        end
        chk(p == 1 ? timer2_capture_reload_trigger : timer1_external_input,
            s == 8'h02, "level in");
        @(posedge pclk);
        pad_in[p] <= 1'b0;
        pulses = 0;
        for (k = 0; k < 8; k++) begin
            settle(1);
            if ((p == 1 ? io_interrupt_input_3 : io_interrupt_input_2) === 1'b1) pulses++;
        end
        chk(pulses, s == 8'h03, "fall irq");
        if (p == 2) chk(uart1_receive_in, s != 8'h01, "rx level");
    endtask

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    initial begin
        #400000;
        fails++;
        report_and_stop();
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, pad_in, gpio_out} = '0;
        gpio_out = 14'h1520;
        pstrb = 4'hF;
        gpio_oe = 14'h3FFF;
        {uart1_transmit_out, energy_pulse_path1, energy_pulse_path2} = 3'b110;
        {divided_pll_pulse_out, pll_second_pulse} = 2'b10;
        lcd_backplane_in = 8'h65;
        lcd_segment_lo_in = 2'b01;
        lcd_segment_hi_in = 2'b10;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 7; i++) rdchk(regs[i], 8'h00, 1'b0);
        for (i = 0; i < 4; i++) begin
            wr(regs[i], 8'h5A);
            rdchk(regs[i], 8'h5A, 1'b0);
            wr(regs[i], 8'h00);
        end
        rdchk(14'h0001, 8'h00, 1'b1);
        @(posedge pclk);
        pstrb <= 4'hE;
        wr(IDX_LCD_CTRL, 8'h33);
        @(posedge pclk);
        pstrb <= 4'hF;
        rdchk(IDX_LCD_CTRL, 8'h00, 1'b0);
        for (i = 0; i < 5; i++) pin_fn(IDX_PIN23_FSEL, 1, sels[i]);
        for (i = 0; i < 5; i++) pin_fn(IDX_PIN24_FSEL, 2, sels[i]);
        wr(IDX_FAST_IO_CF, 8'h68);
        settle(2);
        chk({pad_oe[5:3], pad_out[5:3]}, 6'h3D, "cf pll a");
        @(posedge pclk);
        {energy_pulse_path1, energy_pulse_path2} <= 2'b01;
        {divided_pll_pulse_out, pll_second_pulse} <= 2'b01;
        settle(2);
        chk({pad_oe[5:3], pad_out[5:3]}, 6'h3A, "cf pll b");
        wr(IDX_PLL_CFG, 8'h01);
        settle(2);
        chk(pad_out[5], 1'b1, "second pulse");
        wr(IDX_FAST_IO_CF, 8'h00);
        settle(2);
        chk({pad_oe[5:3], pad_out[5:3]}, 6'h3C, "fast gpio");
        chk(pad_out[13:6], 8'h54, "lcd default gpio");
        wr(IDX_LCD_PIN_EN, 8'h07);
        for (j = 0; j < 4; j++) begin
            lt = j[1:0];
            wr(IDX_LCD_CTRL, {2'b00, lt, 4'h0});
            settle(2);
            chk(pad_out[13:6], {lt < 2 ? 2'b10 : 2'b01, lt == 0 ? 2'b01 : 2'b10, 4'h5},
                "lcd pins");
        end
        for (i = 0; i < 3; i++) begin
            wr(IDX_WAKE_CFG, wcfg[i]);
            @(posedge pclk);
            pad_in[0] <= 1'b1;
            settle(6);
            chk(wake_input_2, wcfg[i] != 8'h05, "wake rise");
            chk(gpio_in[0], 1'b1, "pad sync level");
            wr(IDX_PIN_STATUS, 8'h80);
            settle(1);
            chk(wake_input_2, 1'b0, "wake clear");
            @(posedge pclk);
            pad_in[0] <= 1'b0;
            settle(6);
            rdchk(IDX_PIN_STATUS, {wcfg[i] != 8'h03, 7'h00}, 1'b0);
            wr(IDX_PIN_STATUS, 8'h80);
        end
        report_and_stop();
    end
endmodule
